// ==== chd_consts.svh ====
// Constants for the CIC and halfband decimator chain
`ifndef CHD_CONSTS_SVH
`define CHD_CONSTS_SVH
// Configuration word addresses on the link
`define CHD_CW0_ADDR    8'h00
`define CHD_CW7_ADDR    8'h07
// Configuration word 0 fields
`define CHD_BYP_BIT     6
`define CHD_DEC_LSB     7
`define CHD_DEC_MSB     12
`define CHD_GAIN_LSB    13
`define CHD_GAIN_MSB    16
`define CHD_SYNC_BIT    19
// Configuration word 7 halfband enables, first stage bit
`define CHD_HB_LSB      15
// Shifter and arithmetic
`define CHD_SHIFT_MAX   5'h0f
`define CHD_CIC_IN_W    15
`define CHD_HB_CENTER   16'h4000
`define CHD_COEF_FRAC   15
// Largest decimation field (ratio minus one) per gain code
`define CHD_MAXF0       6'h1f
`define CHD_MAXF1       6'h1a
`define CHD_MAXF2       6'h17
`define CHD_MAXF3       6'h14
`define CHD_MAXF4       6'h11
`define CHD_MAXF5       6'h0f
`define CHD_MAXF6       6'h0b
`define CHD_MAXF7       6'h09
// Controller register offsets
`define CHD_REG_CW0     4'h0
`define CHD_REG_CW7     4'h1
`define CHD_REG_CTRL    4'h2
`define CHD_REG_STAT    4'h3
`define CHD_REG_DATA    4'h4
// Controller register fields
`define CHD_CTRL_SYNC   8
`endif

// ==== chd_control_end.sv ====
// Source and controller end: feeds samples, writes configuration, collects output
`include "chd_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module chd_control_end #(
	parameter int MIX_W = 20
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// Register port
	input  wire logic [3:0]        regAddr,
	input  wire logic [31:0]       regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic [31:0]            regRdata,
	// Sample source
	input  wire logic              srcValid,
	input  wire logic [MIX_W-1:0]  srcData,
	output logic                   srcReady,
	// Filtered output
	output logic                   sinkValid,
	output logic [23:0]            sinkData,
	// Link
	chd_link.ctl                   lnk
);
	// Largest ratio-minus-one field allowed for a gain code
	function automatic logic [5:0] maxDecField(input logic [2:0] code);
		case (code)
			3'h0:    maxDecField = `CHD_MAXF0;
			3'h1:    maxDecField = `CHD_MAXF1;
			3'h2:    maxDecField = `CHD_MAXF2;
			3'h3:    maxDecField = `CHD_MAXF3;
			3'h4:    maxDecField = `CHD_MAXF4;
			3'h5:    maxDecField = `CHD_MAXF5;
			3'h6:    maxDecField = `CHD_MAXF6;
			default: maxDecField = `CHD_MAXF7;
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Registers and configuration writes
	logic [31:0] cw0;
	logic [31:0] cw7;
	logic [2:0]  gainCode;
	logic [15:0] outCount;
	logic [23:0] lastOut;
	logic        cfgWrite;
	logic [7:0]  cfgAddr;
	logic [31:0] cfgData;
	logic        syncOut;
	logic [31:0] next_cw0;
	logic [31:0] next_cw7;
	logic [2:0]  next_gainCode;
	logic [15:0] next_outCount;
	logic [23:0] next_lastOut;
	logic        next_cfgWrite;
	logic [7:0]  next_cfgAddr;
	logic [31:0] next_cfgData;
	logic        next_syncOut;
	logic [31:0] next_regRdata;
	logic [31:0] clamped;

	// Decimation is capped so the 40-bit integrator cannot overflow
	always_comb begin
		clamped = regWdata;
		if (regWdata[`CHD_DEC_MSB:`CHD_DEC_LSB] > maxDecField(gainCode)) begin
			clamped[`CHD_DEC_MSB:`CHD_DEC_LSB] = maxDecField(gainCode);
		end
		next_cw0      = cw0;
		next_cw7      = cw7;
		next_gainCode = gainCode;
		next_cfgWrite = 1'b0;
		next_cfgAddr  = cfgAddr;
		next_cfgData  = cfgData;
		next_syncOut  = 1'b0;
		if (regWrite) begin
			case (regAddr)
				`CHD_REG_CW0: begin
					next_cw0      = clamped;
					next_cfgWrite = 1'b1;
					next_cfgAddr  = `CHD_CW0_ADDR;
					next_cfgData  = clamped;
				end
				`CHD_REG_CW7: begin
					next_cw7      = regWdata;
					next_cfgWrite = 1'b1;
					next_cfgAddr  = `CHD_CW7_ADDR;
					next_cfgData  = regWdata;
				end
				`CHD_REG_CTRL: begin
					next_gainCode = regWdata[2:0];
					next_syncOut  = regWdata[`CHD_CTRL_SYNC];
				end
				default: begin
				end
			endcase
		end
		next_outCount = lnk.outValid ? outCount + 16'h0001 : outCount;
		next_lastOut  = lnk.outValid ? lnk.outData : lastOut;
		next_regRdata = '0;
		if (regRead) begin
			case (regAddr)
				`CHD_REG_CW0:  next_regRdata = cw0;
				`CHD_REG_CW7:  next_regRdata = cw7;
				`CHD_REG_CTRL: next_regRdata = {29'h0000000, gainCode};
				`CHD_REG_STAT: next_regRdata = {16'h0000, outCount};
				`CHD_REG_DATA: next_regRdata = {{8{lastOut[23]}}, lastOut};
				default:       next_regRdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cw0      <= '0;
			cw7      <= '0;
			gainCode <= '0;
			outCount <= '0;
			lastOut  <= '0;
			cfgWrite <= 1'b0;
			cfgAddr  <= '0;
			cfgData  <= '0;
			syncOut  <= 1'b0;
			regRdata <= '0;
		end else begin
			cw0      <= next_cw0;
			cw7      <= next_cw7;
			gainCode <= next_gainCode;
			outCount <= next_outCount;
			lastOut  <= next_lastOut;
			cfgWrite <= next_cfgWrite;
			cfgAddr  <= next_cfgAddr;
			cfgData  <= next_cfgData;
			syncOut  <= next_syncOut;
			regRdata <= next_regRdata;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Sample feeder: a gap cycle follows each sample while CIC is bypassed
	chd_pkg::chd_feed_t state;
	chd_pkg::chd_feed_t next_state;
	logic               qualN;
	logic [MIX_W-1:0]   sample;
	logic [2:0]         pins;
	logic               next_qualN;
	logic [MIX_W-1:0]   next_sample;
	logic [2:0]         next_pins;

	assign srcReady = (state == chd_pkg::ST_IDLE);

	always_comb begin
		next_state  = state;
		next_qualN  = 1'b1;
		next_sample = sample;
		next_pins   = pins;
		case (state)
			chd_pkg::ST_IDLE: begin
				if (srcValid) begin
					next_qualN  = 1'b0;
					next_sample = srcData;
					next_pins   = gainCode;
					if (cw0[`CHD_BYP_BIT]) begin
						next_state = chd_pkg::ST_GAP;
					end
				end
			end
			chd_pkg::ST_GAP: next_state = chd_pkg::ST_IDLE;
			default:         next_state = chd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state     <= chd_pkg::ST_IDLE;
			qualN     <= 1'b1;
			sample    <= '0;
			pins      <= '0;
			sinkValid <= 1'b0;
			sinkData  <= '0;
		end else begin
			state     <= next_state;
			qualN     <= next_qualN;
			sample    <= next_sample;
			pins      <= next_pins;
			sinkValid <= lnk.outValid;
			sinkData  <= lnk.outValid ? lnk.outData : sinkData;
		end
	end

	// Link drive, all from flip-flops
	assign lnk.sampleQualifyN     = qualN;
	assign lnk.mixerSample        = sample;
	assign lnk.coarseGainStepPins = pins;
	assign lnk.multiPartSyncIn    = syncOut;
	assign lnk.cfgWrite           = cfgWrite;
	assign lnk.cfgAddr            = cfgAddr;
	assign lnk.cfgData            = cfgData;
endmodule
`default_nettype wire

// ==== chd_device_end.sv ====
// Decimator end: rounding, barrel shift, fifth-order CIC, five halfbands
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "chd_consts.svh"
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Config bit bypasses CIC to halfbands
// - Barrel shift before integrators, 6 dB steps
// - Shift equals shift gain plus pins
// - Shift sum saturates at fifteen
// - Gain pins pipelined with their sample
// - Five integrators then five combs
// - Word 0 bits 12-7 hold ratio minus one
// - Word 0 bits 16-13 hold shift gain
// - Source gaps samples while CIC bypassed
// - 15-bit input, accumulators 40,36,32,32,32
// - Keep decimation at most 32, no offset
// - Shift gain from 39 minus bits formula
// - Gain pins give 0 to 42 dB
// - Max decimation falls with gain code
// - Sync enable reloads counter on first pulse
// - Five halfbands, each decimates by two
// - Halfbands have 7,11,15,19,23 taps
// - Word 7 bits 15-19 enable halfbands
// - Mixer product symmetrically rounded to 15 bits
module chd_device_end #(
	parameter int MIX_W = 20
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Link to source, controller and filter
	chd_link.dev      lnk
);
	localparam int RS = MIX_W - `CHD_CIC_IN_W;

	//////////////////////////////////////////////////////////////////////////
	// Configuration words
	logic [31:0] cw0;
	logic [31:0] cw7;
	logic [31:0] next_cw0;
	logic [31:0] next_cw7;

	always_comb begin
		next_cw0 = cw0;
		next_cw7 = cw7;
		if (lnk.cfgWrite && lnk.cfgAddr == `CHD_CW0_ADDR) begin
			next_cw0 = lnk.cfgData;
		end
		if (lnk.cfgWrite && lnk.cfgAddr == `CHD_CW7_ADDR) begin
			next_cw7 = lnk.cfgData;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cw0 <= '0;
			cw7 <= '0;
		end else begin
			cw0 <= next_cw0;
			cw7 <= next_cw7;
		end
	end

	wire logic       bypass   = cw0[`CHD_BYP_BIT];
	wire logic [5:0] decField = cw0[`CHD_DEC_MSB:`CHD_DEC_LSB];
	wire logic [3:0] shiftGain = cw0[`CHD_GAIN_MSB:`CHD_GAIN_LSB];
	wire logic       syncEn   = cw0[`CHD_SYNC_BIT];
	wire logic [4:0] hbEnable = cw7[`CHD_HB_LSB +: 5];

	//////////////////////////////////////////////////////////////////////////
	// Rounding and barrel shift front end
	logic signed [14:0] rnd;
	logic [2:0]         gainA;
	logic               vA;
	logic signed [39:0] shifted;
	logic               vB;
	logic signed [14:0] next_rnd;
	logic [2:0]         next_gainA;
	logic               next_vA;
	logic signed [39:0] next_shifted;
	logic               next_vB;
	logic signed [MIX_W:0] biased;
	logic signed [MIX_W:0] quot;
	logic [4:0]         shiftSum;

	// Half-LSB bias is one less for negatives: rounds ties away from zero
	always_comb begin
		biased = (MIX_W+1)'(lnk.mixerSample) + (lnk.mixerSample[MIX_W-1]
			? (MIX_W+1)'((1 << (RS-1)) - 1) : (MIX_W+1)'(1 << (RS-1)));
		quot = biased >>> RS;
		if (quot > (MIX_W+1)'(16383)) begin
			next_rnd = 15'h3fff;
		end else begin
			next_rnd = quot[14:0];
		end
		next_vA    = ~lnk.sampleQualifyN;
		next_gainA = lnk.sampleQualifyN ? gainA : lnk.coarseGainStepPins;
		if (lnk.sampleQualifyN) begin
			next_rnd = rnd;
		end
	end

	// Saturating shift amount, applied in the stage after rounding
	always_comb begin
		shiftSum = 5'(shiftGain) + 5'(gainA);
		if (shiftSum > `CHD_SHIFT_MAX) begin
			shiftSum = `CHD_SHIFT_MAX;
		end
		next_vB      = vA;
		next_shifted = vA ? (40'(rnd) <<< shiftSum) : shifted;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rnd     <= '0;
			gainA   <= '0;
			vA      <= 1'b0;
			shifted <= '0;
			vB      <= 1'b0;
		end else begin
			rnd     <= next_rnd;
			gainA   <= next_gainA;
			vA      <= next_vA;
			shifted <= next_shifted;
			vB      <= next_vB;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// CIC: integrators at input rate, combs at decimated rate
	logic signed [39:0] acc1;
	logic signed [35:0] acc2;
	logic signed [31:0] acc3;
	logic signed [31:0] acc4;
	logic signed [31:0] acc5;
	logic signed [31:0] combD [5];
	logic [5:0]         decCount;
	logic               syncArmed;
	logic               syncPrev;
	logic               cicValid;
	chd_pkg::chd_sample_t cicData;
	logic signed [39:0] next_acc1;
	logic signed [35:0] next_acc2;
	logic signed [31:0] next_acc3;
	logic signed [31:0] next_acc4;
	logic signed [31:0] next_acc5;
	logic signed [31:0] next_combD [5];
	logic [5:0]         next_decCount;
	logic               next_syncArmed;
	logic               next_cicValid;
	chd_pkg::chd_sample_t next_cicData;
	logic signed [31:0] comb [6];
	logic               syncPulse;

	// Wrap-around integrators; LSBs dropped after the first and second stages only
	always_comb begin
		next_acc1 = acc1;
		next_acc2 = acc2;
		next_acc3 = acc3;
		next_acc4 = acc4;
		next_acc5 = acc5;
		if (vB && !bypass) begin
			next_acc1 = acc1 + shifted;
			next_acc2 = acc2 + acc1[39:4];
			next_acc3 = acc3 + acc2[35:4];
			next_acc4 = acc4 + acc3;
			next_acc5 = acc5 + acc4;
		end
	end

	// Counter reload and comb section
	always_comb begin
		syncPulse      = lnk.multiPartSyncIn && !syncPrev;
		next_syncArmed = syncArmed;
		next_decCount  = decCount;
		next_combD     = combD;
		next_cicValid  = 1'b0;
		next_cicData   = cicData;
		comb[0]        = acc5;
		for (int i = 1; i < 6; i++) begin
			comb[i] = comb[i-1] - combD[i-1];
		end
		if (lnk.cfgWrite && lnk.cfgAddr == `CHD_CW0_ADDR) begin
			next_syncArmed = lnk.cfgData[`CHD_SYNC_BIT];
		end
		if (syncEn && syncArmed && syncPulse) begin
			next_decCount  = decField;
			next_syncArmed = 1'b0;
		end else if (bypass) begin
			next_cicValid = vB;
			next_cicData  = vB ? shifted[29:6] : cicData;
		end else if (vB) begin
			if (decCount == '0) begin
				next_decCount = decField;
				next_cicValid = 1'b1;
				for (int i = 0; i < 5; i++) begin
					next_combD[i] = comb[i];
				end
				next_cicData = comb[5][31:8];
			end else begin
				next_decCount = decCount - 6'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc1      <= '0;
			acc2      <= '0;
			acc3      <= '0;
			acc4      <= '0;
			acc5      <= '0;
			for (int i = 0; i < 5; i++) begin
				combD[i] <= '0;
			end
			decCount  <= '0;
			syncArmed <= 1'b0;
			syncPrev  <= 1'b0;
			cicValid  <= 1'b0;
			cicData   <= '0;
		end else begin
			acc1      <= next_acc1;
			acc2      <= next_acc2;
			acc3      <= next_acc3;
			acc4      <= next_acc4;
			acc5      <= next_acc5;
			combD     <= next_combD;
			decCount  <= next_decCount;
			syncArmed <= next_syncArmed;
			syncPrev  <= lnk.multiPartSyncIn;
			cicValid  <= next_cicValid;
			cicData   <= next_cicData;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Halfband chain, first stage to last
	logic                 hbV [6];
	chd_pkg::chd_sample_t hbD [6];
	localparam int HB_TAPS [5] = '{7, 11, 15, 19, 23};

	assign hbV[0] = cicValid;
	assign hbD[0] = cicData;

	genvar s;
	generate
		for (s = 0; s < 5; s++) begin : g_hb
			chd_halfband_stage #(
				.TAPS(HB_TAPS[s]),
				.W   (24)
			) i_chd_halfband_stage (
				.clk     (clk),
				.nrst    (nrst),
				.enable  (hbEnable[s]),
				.inValid (hbV[s]),
				.inData  (hbD[s]),
				.outValid(hbV[s+1]),
				.outData (hbD[s+1])
			);
		end
	endgenerate

	// Filter side sees the last stage, already registered
	assign lnk.outValid = hbV[5];
	assign lnk.outData  = hbD[5];
endmodule
`default_nettype wire

// ==== chd_halfband_stage.sv ====
// One decimate-by-two halfband stage with pass-through when disabled
`include "chd_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module chd_halfband_stage #(
	parameter int TAPS = 7,
	parameter int W    = 24,
	parameter logic [16*((TAPS+1)/4)-1:0] SIDE = '0
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Control
	input  wire logic                enable,
	// Upstream samples
	input  wire logic                inValid,
	input  wire logic signed [W-1:0] inData,
	// Downstream samples
	output logic                     outValid,
	output logic signed [W-1:0]      outData
);
	localparam int NS  = (TAPS + 1) / 4;
	localparam int MID = TAPS / 2;
	localparam int SW  = W + 16 + 5;

	logic signed [W-1:0]  line [TAPS];
	logic signed [W-1:0]  next_line [TAPS];
	logic                 phase;
	logic                 next_phase;
	logic                 next_outValid;
	logic signed [W-1:0]  next_outData;
	logic signed [SW-1:0] term [NS+1];
	logic signed [SW-1:0] acc;

	// Delay line shifts on each valid sample
	always_comb begin
		next_line[0] = inValid ? inData : line[0];
		for (int i = 1; i < TAPS; i++) begin
			next_line[i] = inValid ? line[i-1] : line[i];
		end
	end

	// Folded products: zero coefficients at even offsets from the centre tap are skipped
	genvar k;
	generate
		for (k = 0; k < NS; k++) begin : g_side
			assign term[k] = SW'($signed(SIDE[16*k +: 16]))
				* (SW'(next_line[2*k]) + SW'(next_line[TAPS-1-2*k]));
		end
	endgenerate
	assign term[NS] = SW'($signed({1'b0, `CHD_HB_CENTER})) * SW'(next_line[MID]);

	always_comb begin
		acc = '0;
		for (int i = 0; i <= NS; i++) begin
			acc = acc + term[i];
		end
	end

	// Output every second sample, or every sample when bypassed
	always_comb begin
		next_phase    = phase;
		next_outValid = 1'b0;
		next_outData  = outData;
		if (!enable) begin
			next_outValid = inValid;
			next_outData  = inValid ? inData : outData;
			next_phase    = 1'b0;
		end else if (inValid) begin
			next_phase = ~phase;
			if (phase) begin
				next_outValid = 1'b1;
				next_outData  = acc[`CHD_COEF_FRAC +: W];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < TAPS; i++) begin
				line[i] <= '0;
			end
			phase    <= 1'b0;
			outValid <= 1'b0;
			outData  <= '0;
		end else begin
			line     <= next_line;
			phase    <= next_phase;
			outValid <= next_outValid;
			outData  <= next_outData;
		end
	end
endmodule
`default_nettype wire

// ==== chd_link.sv ====
// Link between sample source/controller and the decimator
`timescale 1ns/1ns
`default_nettype none
interface chd_link;
	logic                sampleQualifyN;
	logic signed [19:0]  mixerSample;
	chd_pkg::chd_gain_t  coarseGainStepPins;
	logic                multiPartSyncIn;
	logic                cfgWrite;
	logic [7:0]          cfgAddr;
	logic [31:0]         cfgData;
	logic                outValid;
	chd_pkg::chd_sample_t outData;
	modport dev (
		input  sampleQualifyN, mixerSample, coarseGainStepPins, multiPartSyncIn,
		input  cfgWrite, cfgAddr, cfgData,
		output outValid, outData
	);
	modport ctl (
		output sampleQualifyN, mixerSample, coarseGainStepPins, multiPartSyncIn,
		output cfgWrite, cfgAddr, cfgData,
		input  outValid, outData
	);
endinterface
`default_nettype wire

// ==== chd_link_monitor.sv ====
// Assertions on the link between the control end and the decimator end
`timescale 1ns/1ns
`default_nettype none
module chd_link_monitor (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 nrst,
	// Source side of the link
	input wire logic                 sampleQualifyN,
	input wire logic signed [19:0]   mixerSample,
	input wire chd_pkg::chd_gain_t   coarseGainStepPins,
	input wire logic                 multiPartSyncIn,
	input wire logic                 cfgWrite,
	input wire logic [7:0]           cfgAddr,
	input wire logic [31:0]          cfgData,
	// Filter side of the link
	input wire logic                 outValid,
	input wire chd_pkg::chd_sample_t outData
);
	logic [31:0]        cw0, cw7, next_cw0, next_cw7;
	logic [4:0]         idle, next_idle, shAmt;
	logic signed [20:0] rnd;
	logic signed [39:0] shifted;
	logic [23:0]        bypExp;
	logic               byp;
	////////////////////////////////////////////////////////////////////////////////
	// Shadow config words; idle count saturates so stale samples never look recent
	always_comb begin
		next_cw0 = (cfgWrite && cfgAddr == 8'h00) ? cfgData : cw0;
		next_cw7 = (cfgWrite && cfgAddr == 8'h07) ? cfgData : cw7;
		next_idle = !sampleQualifyN ? 5'h00 : idle + 5'(idle != 5'h1f);
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cw0  <= '0;
			cw7  <= '0;
			idle <= 5'h1f;
		end else begin
			cw0  <= next_cw0;
			cw7  <= next_cw7;
			idle <= next_idle;
		end
	end
	// Bypass path model: round to 15 bits, then shift by the clamped gain sum
	assign shAmt = 5'(cw0[16:13]) + 5'(coarseGainStepPins);
	assign rnd = (21'(mixerSample) + (mixerSample[19] ? 21'sh0f : 21'sh10)) >>> 5;
	assign shifted = 40'(rnd > 21'sh3fff ? 21'sh3fff : rnd) <<< (shAmt > 5'h0f ? 5'h0f : shAmt);
	assign bypExp = shifted[29:6];
	assign byp = cw0[6] && cw7[20:15] == 6'h00;
	////////////////////////////////////////////////////////////////////////////////
	// One clock domain, so clocking and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_byp_data: assert property (
		!sampleQualifyN && byp |-> ##8 outValid && outData == $past(bypExp, 8))
		else $error("bypass output late or wrong");
	a_byp_cause: assert property (
		outValid && byp |-> $past(sampleQualifyN, 8) == 1'b0)
		else $error("bypass output without a sample");
	a_byp_gap: assert property (
		!sampleQualifyN && cw0[6] |=> sampleQualifyN)
		else $error("no gap between bypassed samples");
	a_out_cause: assert property (
		outValid |-> idle < 5'h18)
		else $error("output long after last sample");
	a_out_hold: assert property (
		!outValid |-> $stable(outData))
		else $error("output data moved without strobe");
	a_pins_hold: assert property (
		sampleQualifyN |-> $stable(mixerSample) && $stable(coarseGainStepPins))
		else $error("sample or gain moved between samples");
	a_sync_pulse: assert property (
		multiPartSyncIn |=> !multiPartSyncIn)
		else $error("sync pulse too long");
	a_dec_cap: assert property (
		cfgWrite && cfgAddr == 8'h00 |-> cfgData[12:7] <= 6'h1f)
		else $error("decimation field above limit");
endmodule
`default_nettype wire

// ==== chd_pkg.sv ====
// Types shared by both ends of the decimator link
package chd_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_GAP  = 2'b10
	} chd_feed_t;
	typedef logic signed [23:0] chd_sample_t;
	typedef logic [2:0] chd_gain_t;
endpackage

// ==== cic_halfband_decimator_bench.sv ====
// Self-checking bench: control end and decimator end joined by the link
`include "chd_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module cic_halfband_decimator_bench;
	logic        clk, nrst, regWrite, regRead, srcValid, srcReady, sinkValid;
	logic [3:0]  regAddr, shGain;
	logic [31:0] regWdata, regRdata, v;
	logic [19:0] srcData, m;
	logic [23:0] sinkData, lastExp;
	logic [23:0] expQ[$];
	logic [19:0] corner[4] = '{20'h7ffff, 20'h80000, 20'h00010, 20'hffff0};
	logic [4:0]  masks[7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h15, 5'h1f};
	logic [5:0]  f;
	logic [2:0]  gc;
	int          maxDec[8] = '{32, 27, 24, 21, 18, 16, 12, 10};
	int          err_total, checked, outs, seed;
	chd_link lnk();
	////////////////////////////////////////////////////////////////////////////////
	// Both ends and the link checker
	chd_control_end i_chd_control_end (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .srcValid(srcValid), .srcData(srcData),
		.srcReady(srcReady), .sinkValid(sinkValid), .sinkData(sinkData), .lnk(lnk.ctl));
	chd_device_end i_chd_device_end (.clk(clk), .nrst(nrst), .lnk(lnk.dev));
	chd_link_monitor i_chd_link_monitor (.clk(clk), .nrst(nrst), .sampleQualifyN(lnk.sampleQualifyN),
		.mixerSample(lnk.mixerSample), .coarseGainStepPins(lnk.coarseGainStepPins),
		.multiPartSyncIn(lnk.multiPartSyncIn), .cfgWrite(lnk.cfgWrite), .cfgAddr(lnk.cfgAddr),
		.cfgData(lnk.cfgData), .outValid(lnk.outValid), .outData(lnk.outData));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Expected bypass sample: ties round away from zero, gain sum stops at 15
	function automatic logic [23:0] exp_byp(input logic [19:0] x, input logic [3:0] s, input logic [2:0] g);
		logic signed [20:0] r;
		logic signed [39:0] w;
		logic [4:0]         n;
		r = ($signed({x[19], x}) + (x[19] ? 21'sh0f : 21'sh10)) >>> 5;
		n = 5'(s) + 5'(g);
		w = 40'(r > 21'sh3fff ? 21'sh3fff : r) <<< (n > 5'h0f ? 5'h0f : n);
		return w[29:6];
	endfunction
	// Largest shift gain whose R^5 growth plus 15 input bits still fits 40 bits
	function automatic logic [3:0] shift_for(input int r);
		longint p;
		p = longint'(r) ** 5;
		for (int s = 15; s > 0; s--) begin
			if ((longint'(1) << (25 - s)) >= p) return 4'(s);
		end
		return 4'h0;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	// Register strobes get an idle cycle after them so no signal is driven twice at one edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdata;
		@(posedge clk);
	endtask
	// Ready is looked at mid-cycle, where it is settled for the next edge
	task automatic send(input logic [19:0] d, input logic last);
		srcData <= d;
		srcValid <= 1'b1;
		@(negedge clk);
		for (int n = 0; n < 8 && srcReady !== 1'b1; n++) @(negedge clk);
		if (srcReady !== 1'b1) err_total++;
		@(posedge clk);
		if (last) begin
			srcValid <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		expQ.delete();
		@(posedge clk);
	endtask
	// One CIC and halfband setting from reset, counted at the sink and in status
	task automatic run(input logic [5:0] fd, input logic [4:0] hb, input int n);
		do_reset();
		wr(`CHD_REG_CW7, 32'(hb) << 15);
		wr(`CHD_REG_CW0, (32'(fd) << 7) | (32'(shift_for(fd + 1)) << 13));
		for (int i = 0; i < n; i++) send(20'($random(seed)), i == n - 1);
		repeat (80) @(posedge clk);
		rd(`CHD_REG_STAT, v);
		check(32'(v[15:0]), 32'(n / ((fd + 1) << $countones(hb))));
		check(32'(outs), 32'(n / ((fd + 1) << $countones(hb))));
		$display("run field %0d stages %h done", fd, hb);
	endtask
	task automatic close_out();
		$display("compares %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Sink counter; bypass outputs are matched in order
	always @(posedge clk) begin
		if (!nrst)
			outs = 0;
		else if (sinkValid === 1'b1) begin
			outs++;
			if (expQ.size() > 0) check(32'(sinkData), 32'(expQ.pop_front()));
		end
	end
	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		#300000;
		err_total++;
		close_out();
	end
	// Main sequence
	initial begin
		seed = 74;
		nrst = 1'b0;
		{regWrite, regRead, srcValid, regAddr, regWdata, srcData} = '0;
		@(posedge clk);
		do_reset();
		for (int g = 0; g < 8; g++) begin
			wr(`CHD_REG_CTRL, 32'(g));
			wr(`CHD_REG_CW0, 32'h0000_1f80);
			rd(`CHD_REG_CW0, v);
			check(32'(v[12:7]), 32'(maxDec[g] - 1));
		end
		rd(4'hf, v);
		check(v, 32'h0);
		$display("clamp table done");
		// Pass 0: saturating gain, new code per sample after the four corners; pass 1: back to back, refused gaps
		for (int p = 0; p < 2; p++) begin
			do_reset();
			shGain = p ? 4'($random(seed)) : 4'hf;
			gc = p ? 3'($random(seed)) : 3'h7;
			wr(`CHD_REG_CW0, 32'h40 | (32'(shGain) << 13));
			wr(`CHD_REG_CTRL, 32'(gc));
			for (int i = 0; i < 24; i++) begin
				m = i < 4 ? corner[i] : 20'($random(seed));
				if (p == 0 && i >= 4) begin
					gc = 3'($random(seed));
					wr(`CHD_REG_CTRL, 32'(gc));
				end
				lastExp = exp_byp(m, shGain, gc);
				expQ.push_back(lastExp);
				send(m, p == 0 || i == 23);
			end
			repeat (20) @(posedge clk);
			check(32'(expQ.size()), 32'h0);
			rd(`CHD_REG_DATA, v);
			check(v, {{8{lastExp[23]}}, lastExp});
			$display("bypass pass %0d done", p);
		end
		run(6'h00, 5'h00, 4);
		run(6'h01, 5'h00, 6);
		run(6'h1f, 5'h00, 96);
		f = 6'($random(seed)) & 6'h1f;
		run(f, 5'h00, 3 * (f + 1));
		foreach (masks[k]) run(6'h00, masks[k], 32);
		// Sync reload: ratio 4, two samples, sync, then the count restarts
		do_reset();
		wr(`CHD_REG_CW0, 32'h0008_0180);
		for (int i = 0; i < 6; i++) begin
			if (i == 2) begin
				wr(`CHD_REG_CTRL, 32'h100);
				repeat (3) @(posedge clk);
			end
			send(20'($random(seed)), 1'b1);
			repeat (20) @(posedge clk);
			if (i >= 4) check(32'(outs), i == 4 ? 32'h1 : 32'h2);
		end
		$display("sync reload done");
		close_out();
	end
endmodule
`default_nettype wire
